// [core/uar_core.sv]
// full-duplex asynchronous serial transceiver with register port
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/100ps

module uar_core (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic clock_en_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [7:0] rdata_out,
  input wire logic rx_pad_in,
  output logic tx_pad_out,
  output logic high_priority_irq_line_out_1,
  output logic high_priority_irq_line_out_0,
  output logic crystal_clock_select_out
);

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} uar_rx_state_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} uar_tx_state_t;

  uar_pkg::uar_command_t command_r;
  uar_pkg::uar_control_t control_r;
  logic [7:0] transmit_byte_r;
  logic [7:0] received_byte_r;
  logic transmit_pending_r;
  logic receive_pending_r;
  logic overrun_flag_r;
  logic start_error_flag_r;
  logic parity_error_flag_r;
  logic frame_error_flag_r;
  logic rx_meta_r;
  logic rx_sync_r;
  logic [15:0] baud_cnt_r;
  logic os_tick;
  logic rx_line;
  logic rx_enabled;
  uar_rx_state_t rx_state_r;
  logic [3:0] rx_tick_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_shift_r;
  logic rx_start_err_r;
  logic rx_parity_err_r;
  logic rx_done;
  logic rx_frame_ok;
  uar_tx_state_t tx_state_r;
  logic [3:0] tx_tick_r;
  logic [3:0] tx_left_r;
  logic [10:0] tx_shift_r;
  logic tx_load;
  logic wr_tx_hold;
  logic wr_rx_status;
  logic rd_rx_hold;

  // oversampling-tick divider per baud code; prescaler code is only stored and read back
  function automatic logic [15:0] baud_divisor(input logic [2:0] code);
    case (code)
      3'h7: baud_divisor = uar_pkg::DIV_115200;
      3'h6: baud_divisor = uar_pkg::DIV_57600;
      3'h5: baud_divisor = uar_pkg::DIV_9600;
      3'h4: baud_divisor = uar_pkg::DIV_14400;
      3'h3: baud_divisor = uar_pkg::DIV_2400;
      3'h2: baud_divisor = uar_pkg::DIV_1200;
      3'h1: baud_divisor = uar_pkg::DIV_600;
      default: baud_divisor = uar_pkg::DIV_300;
    endcase
  endfunction

  // parity bit for the word, masked to the word length
  function automatic logic parity_of(input logic [7:0] data, input logic eight,
                                     input logic even);
    parity_of = (^{data[7] & eight, data[6:0]}) ^ ~even;
  endfunction

  assign wr_tx_hold = clock_en_in & write_in & (addr_in == uar_pkg::ADDR_TX_HOLD);
  assign wr_rx_status = clock_en_in & write_in & (addr_in == uar_pkg::ADDR_RX_STATUS);
  assign rd_rx_hold = clock_en_in & read_in & (addr_in == uar_pkg::ADDR_RX_HOLD);

  // configuration registers
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      command_r <= uar_pkg::COMMAND_RESET;
      control_r <= uar_pkg::CONTROL_RESET;
    end
    else if (clock_en_in && write_in)
    begin
      if (addr_in == uar_pkg::ADDR_COMMAND)
        command_r <= wdata_in;
      if (addr_in == uar_pkg::ADDR_CONTROL)
        control_r <= wdata_in;
    end
  end

  // source select only reaches the clock tree outside this block
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      crystal_clock_select_out <= 1'b0;
    else if (clock_en_in)
      crystal_clock_select_out <= command_r.crystal_clock_select;
  end

  // read port: data only in the cycle after the strobe
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      rdata_out <= 8'h00;
    else if (clock_en_in)
    begin
      rdata_out <= 8'h00;
      if (read_in)
      begin
        case (addr_in)
          uar_pkg::ADDR_COMMAND: rdata_out <= command_r;
          uar_pkg::ADDR_CONTROL: rdata_out <= control_r;
          uar_pkg::ADDR_TX_HOLD: rdata_out <= transmit_byte_r;
          uar_pkg::ADDR_TX_STATUS: rdata_out <= {6'h00, tx_state_r == TX_SHIFT,
                                                 transmit_pending_r};
          uar_pkg::ADDR_RX_HOLD: rdata_out <= received_byte_r;
          uar_pkg::ADDR_RX_STATUS: rdata_out <= {2'h0, start_error_flag_r,
                                                 parity_error_flag_r, frame_error_flag_r,
                                                 overrun_flag_r, rx_state_r != RX_IDLE,
                                                 receive_pending_r};
          default: rdata_out <= 8'h00;
        endcase
      end
    end
  end

  // oversampling tick generator
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      baud_cnt_r <= 16'h0000;
    else if (clock_en_in)
    begin
      if (baud_cnt_r >= baud_divisor(control_r.baud_code) - 16'h0001)
        baud_cnt_r <= 16'h0000;
      else
        baud_cnt_r <= baud_cnt_r + 16'h0001;
    end
  end

  assign os_tick = clock_en_in && (baud_cnt_r >= baud_divisor(control_r.baud_code) - 16'h0001);

  // receive pad synchroniser
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end
    else if (clock_en_in)
    begin
      rx_meta_r <= rx_pad_in;
      rx_sync_r <= rx_meta_r;
    end
  end

  assign rx_line = rx_sync_r ^ control_r.receive_invert;
  assign rx_enabled = command_r.receive_enable_b | control_r.receive_enable_a;

  // receiver sequence
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rx_state_r <= RX_IDLE;
      rx_tick_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_shift_r <= 8'h00;
      rx_start_err_r <= 1'b0;
      rx_parity_err_r <= 1'b0;
    end
    else if (clock_en_in)
    begin
      case (rx_state_r)
        RX_IDLE:
        begin
          rx_tick_r <= 4'h0;
          rx_bit_r <= 3'h0;
          rx_start_err_r <= 1'b0;
          rx_parity_err_r <= 1'b0;
          if (rx_enabled && !rx_line)
            rx_state_r <= RX_START;
        end
        RX_START:
        begin
          if (os_tick)
          begin
            rx_tick_r <= rx_tick_r + 4'h1;
            // a glitch still runs a frame so the error is reported
            if (rx_tick_r == uar_pkg::MID_TICK && rx_line)
              rx_start_err_r <= 1'b1;
            if (rx_tick_r == uar_pkg::LAST_TICK)
              rx_state_r <= RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (os_tick)
          begin
            rx_tick_r <= rx_tick_r + 4'h1;
            if (rx_tick_r == uar_pkg::MID_TICK)
              rx_shift_r <= command_r.word_length_sel ? {rx_line, rx_shift_r[7:1]}
                                                      : {1'b0, rx_line, rx_shift_r[6:1]};
            if (rx_tick_r == uar_pkg::LAST_TICK)
            begin
              rx_bit_r <= rx_bit_r + 3'h1;
              if (rx_bit_r == {2'h3, command_r.word_length_sel})
                rx_state_r <= command_r.parity_on ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY:
        begin
          if (os_tick)
          begin
            rx_tick_r <= rx_tick_r + 4'h1;
            if (rx_tick_r == uar_pkg::MID_TICK)
              rx_parity_err_r <= rx_line != parity_of(rx_shift_r, command_r.word_length_sel,
                                                      command_r.parity_sense);
            if (rx_tick_r == uar_pkg::LAST_TICK)
              rx_state_r <= RX_STOP;
          end
        end
        RX_STOP:
        begin
          // leave at mid stop so the next start edge is not missed
          if (os_tick)
          begin
            rx_tick_r <= rx_tick_r + 4'h1;
            if (rx_tick_r == uar_pkg::MID_TICK)
              rx_state_r <= RX_IDLE;
          end
        end
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end

  assign rx_done = os_tick && rx_state_r == RX_STOP && rx_tick_r == uar_pkg::MID_TICK;
  assign rx_frame_ok = rx_line;

  // receive holding register and its flags
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      received_byte_r <= uar_pkg::DATA_RESET;
      start_error_flag_r <= 1'b0;
      parity_error_flag_r <= 1'b0;
      frame_error_flag_r <= 1'b0;
    end
    else if (rx_done)
    begin
      received_byte_r <= rx_shift_r;
      start_error_flag_r <= rx_start_err_r;
      parity_error_flag_r <= rx_parity_err_r;
      frame_error_flag_r <= !rx_frame_ok;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      receive_pending_r <= 1'b0;
    else if (rx_done)
      receive_pending_r <= 1'b1;
    else if (rd_rx_hold)
      receive_pending_r <= 1'b0;
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      overrun_flag_r <= 1'b0;
    else if (rx_done && receive_pending_r && !rd_rx_hold)
      overrun_flag_r <= 1'b1;
    else if (wr_rx_status)
      overrun_flag_r <= 1'b0;
  end

  // receive request pulse
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      high_priority_irq_line_out_0 <= 1'b0;
    else
      high_priority_irq_line_out_0 <= rx_done;
  end

  // transmit holding register and pending flag
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      transmit_byte_r <= uar_pkg::DATA_RESET;
    else if (wr_tx_hold)
      transmit_byte_r <= wdata_in;
  end

  assign tx_load = clock_en_in && tx_state_r == TX_IDLE && transmit_pending_r
                   && control_r.transmit_enable;

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      transmit_pending_r <= 1'b0;
    else if (wr_tx_hold)
      transmit_pending_r <= 1'b1;
    else if (tx_load)
      transmit_pending_r <= 1'b0;
  end

  // transmit request on the pending flag's fall
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      high_priority_irq_line_out_1 <= 1'b0;
    else
      high_priority_irq_line_out_1 <= tx_load && !wr_tx_hold;
  end

  // transmit shifter: stop, parity, data, start from top to bottom
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      tx_state_r <= TX_IDLE;
      tx_tick_r <= 4'h0;
      tx_left_r <= 4'h0;
      tx_shift_r <= 11'h7FF;
    end
    else if (clock_en_in)
    begin
      case (tx_state_r)
        TX_IDLE:
        begin
          tx_tick_r <= 4'h0;
          if (tx_load)
          begin
            tx_state_r <= TX_SHIFT;
            tx_left_r <= uar_pkg::FRAME_BITS_BASE - {3'h0, !command_r.word_length_sel}
                         + {3'h0, command_r.parity_on};
            if (command_r.word_length_sel)
              tx_shift_r <= {1'b1, command_r.parity_on ? parity_of(transmit_byte_r, 1'b1,
                             command_r.parity_sense) : 1'b1, transmit_byte_r, 1'b0};
            else
              tx_shift_r <= {2'h3, command_r.parity_on ? parity_of(transmit_byte_r, 1'b0,
                             command_r.parity_sense) : 1'b1, transmit_byte_r[6:0], 1'b0};
          end
        end
        TX_SHIFT:
        begin
          if (os_tick)
          begin
            tx_tick_r <= tx_tick_r + 4'h1;
            if (tx_tick_r == uar_pkg::LAST_TICK)
            begin
              tx_shift_r <= {1'b1, tx_shift_r[10:1]};
              tx_left_r <= tx_left_r - 4'h1;
              if (tx_left_r == 4'h1)
                tx_state_r <= TX_IDLE;
            end
          end
        end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end

  // transmit pad, with echo bypassing the shifter
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      tx_pad_out <= 1'b1;
    else if (clock_en_in)
    begin
      if (control_r.loopback_echo)
        tx_pad_out <= rx_line ^ control_r.transmit_invert;
      else
        tx_pad_out <= tx_shift_r[0] ^ control_r.transmit_invert;
    end
  end

endmodule // uar_core

// [common/uar_pkg.sv]
// constants and field layouts of the serial transceiver
package uar_pkg;

  // register addresses on the local port
  localparam logic [2:0] ADDR_COMMAND = 3'h0;
  localparam logic [2:0] ADDR_CONTROL = 3'h1;
  localparam logic [2:0] ADDR_TX_HOLD = 3'h2;
  localparam logic [2:0] ADDR_TX_STATUS = 3'h3;
  localparam logic [2:0] ADDR_RX_HOLD = 3'h4;
  localparam logic [2:0] ADDR_RX_STATUS = 3'h5;

  typedef struct packed {
    logic crystal_clock_select;
    logic receive_enable_b;
    logic [2:0] rc_prescaler_code;
    logic parity_sense;
    logic parity_on;
    logic word_length_sel;
  } uar_command_t;

  typedef struct packed {
    logic loopback_echo;
    logic receive_enable_a;
    logic transmit_enable;
    logic receive_invert;
    logic transmit_invert;
    logic [2:0] baud_code;
  } uar_control_t;

  // status bit positions
  localparam int TX_PENDING_BIT = 0;
  localparam int TX_ACTIVE_BIT = 1;
  localparam int RX_PENDING_BIT = 0;
  localparam int RX_ACTIVE_BIT = 1;
  localparam int OVERRUN_BIT = 2;
  localparam int FRAME_ERR_BIT = 3;
  localparam int PARITY_ERR_BIT = 4;
  localparam int START_ERR_BIT = 5;

  // values after reset
  localparam logic [7:0] COMMAND_RESET = 8'h01;
  localparam logic [7:0] CONTROL_RESET = 8'h05;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // timing: oversampling per bit, sampling point in the bit
  localparam int CLK_HZ = 125_000_000;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] MID_TICK = 4'h7;
  localparam logic [3:0] LAST_TICK = 4'hF;

  localparam int BAUD_115200 = 115200;
  localparam int BAUD_57600 = 57600;
  localparam int BAUD_14400 = 14400;
  localparam int BAUD_9600 = 9600;
  localparam int BAUD_2400 = 2400;
  localparam int BAUD_1200 = 1200;
  localparam int BAUD_600 = 600;
  localparam int BAUD_300 = 300;

  localparam logic [15:0] DIV_115200 = 16'(CLK_HZ / (OVERSAMPLE * BAUD_115200));
  localparam logic [15:0] DIV_57600 = 16'(CLK_HZ / (OVERSAMPLE * BAUD_57600));
  localparam logic [15:0] DIV_14400 = 16'(CLK_HZ / (OVERSAMPLE * BAUD_14400));
  localparam logic [15:0] DIV_9600 = 16'(CLK_HZ / (OVERSAMPLE * BAUD_9600));
  localparam logic [15:0] DIV_2400 = 16'(CLK_HZ / (OVERSAMPLE * BAUD_2400));
  localparam logic [15:0] DIV_1200 = 16'(CLK_HZ / (OVERSAMPLE * BAUD_1200));
  localparam logic [15:0] DIV_600 = 16'(CLK_HZ / (OVERSAMPLE * BAUD_600));
  localparam logic [15:0] DIV_300 = 16'(CLK_HZ / (OVERSAMPLE * BAUD_300));

  // start, eight data and the stop bit, so back-to-back frames keep their stop
  localparam logic [3:0] FRAME_BITS_BASE = 4'hA;

endpackage

// [tb/uar_core_chk.sv]
// port assertions for the serial transceiver
`timescale 1ns/100ps
module uar_core_chk (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic clock_en_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic [7:0] rdata_out,
  input wire logic rx_pad_in,
  input wire logic tx_pad_out,
  input wire logic high_priority_irq_line_out_1,
  input wire logic high_priority_irq_line_out_0,
  input wire logic crystal_clock_select_out
);
  logic [7:0] cmd_r;
  logic [7:0] ctl_r;

  // shadow copies so pad checks know the live settings
  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cmd_r <= uar_pkg::COMMAND_RESET;
      ctl_r <= uar_pkg::CONTROL_RESET;
    end
    else if (write_in && clock_en_in && addr_in == uar_pkg::ADDR_COMMAND)
      cmd_r <= wdata_in;
    else if (write_in && clock_en_in && addr_in == uar_pkg::ADDR_CONTROL)
      ctl_r <= wdata_in;
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_start_bit;
    (tx_pad_out == ctl_r[3])[*8];
  endsequence
  // margin of a few cycles for the pad synchroniser
  sequence s_rx_steady;
    (ctl_r[7] && $stable(rx_pad_in) && $stable(ctl_r))[*6];
  endsequence

  // pin copies the command register one cycle after it was written
  property p_xtal;
    clock_en_in && write_in && addr_in == uar_pkg::ADDR_COMMAND |->
      ##2 crystal_clock_select_out == $past(wdata_in[7], 2);
  endproperty
  property p_cmd_read;
    read_in && addr_in == uar_pkg::ADDR_COMMAND |=> rdata_out == $past(cmd_r);
  endproperty
  property p_ctl_read;
    read_in && addr_in == uar_pkg::ADDR_CONTROL |=> rdata_out == $past(ctl_r);
  endproperty
  property p_rx_unused;
    read_in && addr_in == uar_pkg::ADDR_RX_STATUS |=> rdata_out[7:6] == 2'h0;
  endproperty
  property p_tx_once;
    high_priority_irq_line_out_1 |=> !high_priority_irq_line_out_1;
  endproperty
  property p_rx_once;
    high_priority_irq_line_out_0 |=> !high_priority_irq_line_out_0;
  endproperty
  property p_tx_start;
    high_priority_irq_line_out_1 && !ctl_r[7] |=> s_start_bit;
  endproperty
  property p_tx_gate;
    !ctl_r[5] |-> !high_priority_irq_line_out_1;
  endproperty
  property p_rx_gate;
    !(ctl_r[6] || cmd_r[6]) |-> !high_priority_irq_line_out_0;
  endproperty
  property p_echo;
    s_rx_steady |-> tx_pad_out == (rx_pad_in ^ ctl_r[4] ^ ctl_r[3]);
  endproperty

  a_xtal: assert property (p_xtal) else $error("clock select output wrong");
  a_cmd_read: assert property (p_cmd_read) else $error("command read back wrong");
  a_ctl_read: assert property (p_ctl_read) else $error("control read back wrong");
  a_rx_unused: assert property (p_rx_unused) else $error("unused status bits set");
  a_tx_once: assert property (p_tx_once) else $error("transmit request too long");
  a_rx_once: assert property (p_rx_once) else $error("receive request too long");
  a_tx_start: assert property (p_tx_start) else $error("start bit missing");
  a_tx_gate: assert property (p_tx_gate) else $error("transmit while disabled");
  a_rx_gate: assert property (p_rx_gate) else $error("receive while disabled");
  a_echo: assert property (p_echo) else $error("echo level wrong");
endmodule // uar_core_chk

bind uar_core uar_core_chk uar_core_chk_inst (
  .clock_in(clock_in), .reset_n_in(reset_n_in), .clock_en_in(clock_en_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
  .rdata_out(rdata_out), .rx_pad_in(rx_pad_in), .tx_pad_out(tx_pad_out),
  .high_priority_irq_line_out_1(high_priority_irq_line_out_1),
  .high_priority_irq_line_out_0(high_priority_irq_line_out_0),
  .crystal_clock_select_out(crystal_clock_select_out));

// [tb/uar_remote_station.sv]
// remote serial station model facing the transceiver pads
`timescale 1ns/100ps
module uar_remote_station #(
  parameter int BIT_CYC = 1072
) (
  input wire logic clock_in,
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'b1;

  // fixed nominal bit time: the station clock never drifts
  task automatic bit_out(input logic v);
    @(posedge clock_in);
    line_out <= v;
    repeat (BIT_CYC - 1) @(posedge clock_in);
  endtask

  task automatic level(input logic v);
    @(posedge clock_in);
    line_out <= v;
  endtask

  task automatic send(input logic [7:0] d, input int nb, input logic pe, input logic ev,
                      input logic bad);
    logic p = 1'b0;
    bit_out(1'b0);
    for (int i = 0; i < nb; i++)
    begin
      bit_out(d[i]);
      p = p ^ d[i];
    end
    if (pe)
      bit_out((ev ? p : ~p) ^ bad);
    bit_out(1'b1);
  endtask

  // samples mid bit; returns during the stop bit
  task automatic recv(input int nb, input logic pe, output logic [7:0] d, output logic p,
                      output logic stop);
    int n = 0;
    d = 8'h00;
    p = 1'b0;
    while (line_in !== 1'b0 && n < 100000)
    begin
      @(posedge clock_in);
      n++;
    end
    repeat (BIT_CYC / 2) @(posedge clock_in);
    for (int i = 0; i < nb; i++)
    begin
      repeat (BIT_CYC) @(posedge clock_in);
      d[i] = line_in;
    end
    if (pe)
    begin
      repeat (BIT_CYC) @(posedge clock_in);
      p = line_in;
    end
    repeat (BIT_CYC) @(posedge clock_in);
    stop = line_in;
  endtask
endmodule // uar_remote_station

// [tb/uar_core_tb_top.sv]
// self-checking bench for the serial transceiver
`timescale 1ns/100ps
module uar_core_tb_top;
  localparam int BIT_CYC = 16 * (uar_pkg::CLK_HZ / (16 * uar_pkg::BAUD_115200));
  logic clock_in;
  logic reset_n_in;
  logic clock_en_in;
  logic xtal_sel;
  logic [2:0] addr_in;
  logic [7:0] wdata_in;
  logic write_in;
  logic read_in;
  logic [7:0] rdata_out;
  logic rx_line;
  logic tx_line;
  logic irq_tx;
  logic irq_rx;
  int err_count = 0;
  int n_tests = 0;
  int n_irq_tx = 0;
  int n_irq_rx = 0;
  logic par;
  logic stp;

  uar_core uar_core_inst (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .clock_en_in(clock_en_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
    .rdata_out(rdata_out), .rx_pad_in(rx_line), .tx_pad_out(tx_line),
    .high_priority_irq_line_out_1(irq_tx), .high_priority_irq_line_out_0(irq_rx),
    .crystal_clock_select_out(xtal_sel));

  uar_remote_station #(.BIT_CYC(BIT_CYC)) station (
    .clock_in(clock_in), .line_in(tx_line), .line_out(rx_line));

  initial
  begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  always @(posedge clock_in)
  begin
    if (irq_tx === 1'b1)
      n_irq_tx++;
    if (irq_rx === 1'b1)
      n_irq_rx++;
  end

  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // gap cycle after each strobe keeps every signal to one assignment a step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    write_in <= 1'b1;
    @(posedge clock_in);
    write_in <= 1'b0;
    @(posedge clock_in);
  endtask

  task automatic rc(input logic [2:0] a, input logic [7:0] exp, input string name);
    logic [7:0] v;
    addr_in <= a;
    read_in <= 1'b1;
    @(posedge clock_in);
    read_in <= 1'b0;
    #1;
    v = rdata_out;
    check(name, v, exp);
    @(posedge clock_in);
  endtask

  task automatic t_reset_map;
    logic [7:0] exp [0:6] = '{8'h01, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [2:0] ro [0:2] = '{uar_pkg::ADDR_TX_STATUS, uar_pkg::ADDR_RX_HOLD, 3'h6};
    for (int i = 0; i < 7; i++)
      rc(3'(i), exp[i], "reset value");
    for (int i = 0; i < 3; i++)
    begin
      wr(ro[i], 8'hFF);
      rc(ro[i], 8'h00, "read only place");
    end
    // a write while the enable is low must leave the register untouched
    clock_en_in <= 1'b0;
    wr(uar_pkg::ADDR_COMMAND, 8'h81);
    clock_en_in <= 1'b1;
    rc(uar_pkg::ADDR_COMMAND, 8'h01, "frozen write");
    wr(uar_pkg::ADDR_COMMAND, 8'h81);
    rc(uar_pkg::ADDR_COMMAND, 8'h81, "clock source");
    check("source pin", {7'h00, xtal_sel}, 8'h01);
  endtask

  task automatic t_transmit;
    logic [7:0] d;
    wr(uar_pkg::ADDR_TX_HOLD, 8'hA5);
    repeat (40) @(posedge clock_in);
    rc(uar_pkg::ADDR_TX_STATUS, 8'h01, "held word");
    check("idle pad", {7'h00, tx_line}, 8'h01);
    wr(uar_pkg::ADDR_CONTROL, 8'h27);
    station.recv(8, 1'b0, d, par, stp);
    check("tx byte", d, 8'hA5);
    check("tx stop", {7'h00, stp}, 8'h01);
    check("tx request", 8'(n_irq_tx), 8'h01);
    repeat (BIT_CYC) @(posedge clock_in);
    wr(uar_pkg::ADDR_COMMAND, 8'h06);
    wr(uar_pkg::ADDR_TX_HOLD, 8'h5B);
    repeat (20) @(posedge clock_in);
    rc(uar_pkg::ADDR_TX_STATUS, 8'h02, "shifting");
    station.recv(7, 1'b1, d, par, stp);
    check("tx short word", d, 8'h5B);
    check("even parity", {7'h00, par}, 8'h01);
    check("tx request", 8'(n_irq_tx), 8'h02);
  endtask

  task automatic t_receive;
    wr(uar_pkg::ADDR_COMMAND, 8'h03);
    wr(uar_pkg::ADDR_CONTROL, 8'h47);
    station.send(8'h3C, 8, 1'b1, 1'b0, 1'b0);
    check("rx request", 8'(n_irq_rx), 8'h01);
    rc(uar_pkg::ADDR_RX_STATUS, 8'h01, "rx ready");
    rc(uar_pkg::ADDR_RX_HOLD, 8'h3C, "rx byte");
    rc(uar_pkg::ADDR_RX_STATUS, 8'h00, "rx taken");
    wr(uar_pkg::ADDR_CONTROL, 8'h07);
    wr(uar_pkg::ADDR_COMMAND, 8'h43);
    station.send(8'h81, 8, 1'b1, 1'b0, 1'b0);
    station.send(8'h42, 8, 1'b1, 1'b0, 1'b1);
    rc(uar_pkg::ADDR_RX_STATUS, 8'h15, "overrun");
    rc(uar_pkg::ADDR_RX_HOLD, 8'h42, "newest byte");
    wr(uar_pkg::ADDR_RX_STATUS, 8'h00);
    rc(uar_pkg::ADDR_RX_STATUS, 8'h10, "overrun cleared");
  endtask

  task automatic t_echo;
    logic [7:0] ctl [0:1] = '{8'h88, 8'h98};
    for (int i = 0; i < 2; i++)
    begin
      wr(uar_pkg::ADDR_CONTROL, ctl[i]);
      for (int lv = 0; lv < 2; lv++)
      begin
        station.level(1'(lv));
        repeat (8) @(posedge clock_in);
        check("echo pad", {7'h00, tx_line}, {7'h00, 1'(lv) ^ ctl[i][4] ^ ctl[i][3]});
      end
    end
    station.level(1'b1);
  endtask

  task automatic stop_test;
    if (err_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    reset_n_in = 1'b0;
    clock_en_in = 1'b1;
    addr_in = 3'h0;
    wdata_in = 8'h00;
    write_in = 1'b0;
    read_in = 1'b0;
    repeat (2) @(posedge clock_in);
    reset_n_in <= 1'b1;
    t_reset_map;
    t_transmit;
    t_receive;
    t_echo;
    stop_test;
  end

  // about five frames at the fastest rate fit well inside this span
  initial
  begin
    repeat (90000) @(posedge clock_in);
    err_count++;
    stop_test;
  end
endmodule // uar_core_tb_top
